//--- design/iat_hyst_cmp.sv
// module: one threshold comparator with hysteresis, upper or lower sense
module iat_hyst_cmp #(
    parameter bit UPPER = 1'b1 // 1: alarm above limit, 0: alarm below limit
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // conversion result
    input wire logic sample_valid,
    input wire logic [11:0] sample,
    // limit and hysteresis
    input wire logic [11:0] limit,
    input wire logic [1:0] hyst,
    // state
    output logic active_ff,
    output logic rise_ff
);
    logic set_cond; // result crosses the limit
    logic clr_cond; // result back past limit by the hysteresis
    logic [12:0] sample_plus_h; // widened so full scale plus hysteresis cannot wrap
    logic [12:0] limit_plus_h;

    // widened sums, compare without overflow
    always_comb begin
        sample_plus_h = {1'b0, sample} + {11'h000, hyst};
        limit_plus_h = {1'b0, limit} + {11'h000, hyst};
        if (UPPER) begin
            set_cond = sample > limit;
            clr_cond = sample_plus_h < {1'b0, limit};
        end else begin
            set_cond = sample < limit;
            clr_cond = {1'b0, sample} > limit_plus_h;
        end
    end

    // active level only moves on a fresh sample; between the two bands it holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff <= 1'b0;
        end else if (sample_valid) begin
            if (!active_ff && set_cond) begin
                active_ff <= 1'b1;
            end else if (active_ff && clr_cond) begin
                active_ff <= 1'b0;
            end
        end
    end

    // one-cycle event when the alarm becomes active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_ff <= 1'b0;
        end else begin
            rise_ff <= sample_valid && !active_ff && set_cond;
        end
    end

endmodule : iat_hyst_cmp

//--- design/iat_input_alarm_regs.sv
// module: input alarm threshold registers with apb slave, comparators and interrupt
// Overview of operation
// - hysteresis from top two bits of byte 3
// - upper limit compares only bits 15:4
// - lower limit compares only bits 15:4
// - upper word byte 2 always reads zero
// - lower word top half reads zero, unwritable
// - upper word bytes little endian, 24h-27h
// - lower word bytes little endian, 28h-2Bh
// - overall alarm is or of tripped flags
//
// The APB interface to the registers is this design's own decision.
module iat_input_alarm_regs #(
    parameter int ADDR_W = 8, // apb address width
    parameter int RESULT_W = 12 // conversion result width
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // conversion results
    input wire logic result_valid,
    input wire logic [RESULT_W-1:0] result,
    // alarm outputs
    output logic active_input_upper,
    output logic active_input_lower,
    output logic tripped_input_upper_flag,
    output logic tripped_input_lower_flag,
    output logic any_tripped_alarm,
    output logic irq
);
    // the comparators are 12 bits wide; the bus decode needs at least a byte of address
    if (RESULT_W != 12) begin : g_bad_result_w
        $error("result width must be 12");
    end
    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("address width must be at least 8");
    end

    logic [15:0] upper_ff; // upper limit field
    logic [7:0] hyst_byte_ff; // hysteresis byte, only 7:6 used
    logic [15:0] lower_ff; // lower limit field
    logic [31:0] mask_ff; // interrupt enables
    logic [31:0] prdata_ff; // read data register
    logic pready_ff; // access phase answer
    logic pslverr_ff; // unmapped address answer
    logic irq_ff; // interrupt level
    logic ovw_ff; // overall alarm pin copy
    logic [31:0] nxt_prdata; // read mux
    logic [31:0] status_word; // live status layout
    logic [31:0] upper_word; // upper register as read
    logic [31:0] lower_word; // lower register as read
    logic [31:0] nxt_upper_word; // upper register after a write
    logic [31:0] nxt_lower_word; // lower register after a write
    logic sel_status, sel_upper, sel_lower, sel_mask, sel_any; // address decode
    logic acc_first; // first access cycle: answer is prepared
    logic wr_go; // completion edge of a write
    logic rd_go; // capture edge of a read
    logic rise_hi, rise_lo; // comparator events
    logic [1:0] trp; // sticky tripped flags {lower, upper}
    iat_pkg::iat_limits_t lim; // comparison view of the limits
    iat_pkg::iat_flags_t flg; // flags for status and pins

    // address decode on the byte offsets, low byte only
    always_comb begin
        sel_status = paddr[7:0] == iat_pkg::OFS_STATUS;
        sel_upper = paddr[7:0] == iat_pkg::OFS_UPPER;
        sel_lower = paddr[7:0] == iat_pkg::OFS_LOWER;
        sel_mask = paddr[7:0] == iat_pkg::OFS_MASK;
        sel_any = sel_status || sel_upper || sel_lower || sel_mask;
    end

    // two-cycle access phase: first cycle prepares data, second answers with pready
    assign acc_first = psel && penable && !pready_ff;
    assign wr_go = psel && penable && pready_ff && pwrite && sel_any;
    assign rd_go = acc_first && !pwrite;

    // registers as software sees them; reserved parts are constant zero
    always_comb begin
        upper_word = {hyst_byte_ff, 8'h00, upper_ff};
        lower_word = {16'h0000, lower_ff};
        nxt_upper_word = iat_pkg::iat_byte_merge(upper_word, pwdata, pstrb);
        nxt_lower_word = iat_pkg::iat_byte_merge(lower_word, pwdata, pstrb);
    end

    // upper register: byte 3 hysteresis, byte 2 dropped, bytes 1:0 limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_ff <= iat_pkg::UPPER_RST;
            hyst_byte_ff <= iat_pkg::HYST_RST;
        end else if (wr_go && sel_upper) begin
            upper_ff <= nxt_upper_word[15:0];
            hyst_byte_ff <= nxt_upper_word[31:24];
        end
    end

    // lower register: only the low half is stored, the top half has no storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_ff <= iat_pkg::LOWER_RST;
        end else if (wr_go && sel_lower) begin
            lower_ff <= nxt_lower_word[15:0];
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= iat_pkg::MASK_RST;
        end else if (wr_go && sel_mask) begin
            mask_ff <= iat_pkg::iat_byte_merge(mask_ff, pwdata, pstrb);
        end
    end

    // comparison view; low nibbles are ignored, so software leaving them nonzero is harmless
    always_comb begin
        lim.hyst = hyst_byte_ff[iat_pkg::HYST_LSB +: 2];
        lim.upper = upper_ff[15:iat_pkg::LIMIT_LSB];
        lim.lower = lower_ff[15:iat_pkg::LIMIT_LSB];
    end

    // upper comparator
    iat_hyst_cmp #(
        .UPPER(1'b1)
    ) u_cmp_upper (
        .pclk(pclk),
        .presetn(presetn),
        .sample_valid(result_valid),
        .sample(result),
        .limit(lim.upper),
        .hyst(lim.hyst),
        .active_ff(flg.act_hi),
        .rise_ff(rise_hi)
    );

    // lower comparator
    iat_hyst_cmp #(
        .UPPER(1'b0)
    ) u_cmp_lower (
        .pclk(pclk),
        .presetn(presetn),
        .sample_valid(result_valid),
        .sample(result),
        .limit(lim.lower),
        .hyst(lim.hyst),
        .active_ff(flg.act_lo),
        .rise_ff(rise_lo)
    );

    // tripped flags, cleared by a status read
    iat_sticky_flags #(
        .W(2)
    ) u_tripped (
        .pclk(pclk),
        .presetn(presetn),
        .set({rise_lo, rise_hi}),
        .clr(rd_go && sel_status),
        .flags_ff(trp)
    );

    assign flg.trp_hi = trp[0];
    assign flg.trp_lo = trp[1];

    // status layout: active in byte 1, tripped and overall alarm in byte 0
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[iat_pkg::STS_ACT_LO_BIT] = flg.act_lo;
        status_word[iat_pkg::STS_ACT_HI_BIT] = flg.act_hi;
        status_word[iat_pkg::STS_TRP_LO_BIT] = flg.trp_lo;
        status_word[iat_pkg::STS_TRP_HI_BIT] = flg.trp_hi;
        status_word[iat_pkg::STS_OVW_BIT] = flg.trp_lo || flg.trp_hi;
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (sel_status) begin
            nxt_prdata = status_word;
        end else if (sel_upper) begin
            nxt_prdata = upper_word;
        end else if (sel_lower) begin
            nxt_prdata = lower_word;
        end else if (sel_mask) begin
            nxt_prdata = mask_ff;
        end
    end

    // bus answer registers; the status is sampled in the same edge that clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= acc_first;
            pslverr_ff <= acc_first && !sel_any;
            if (rd_go) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // interrupt and overall alarm pin, one cycle behind the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
            ovw_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_word & mask_ff);
            ovw_ff <= flg.trp_lo || flg.trp_hi;
        end
    end

    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign any_tripped_alarm = ovw_ff;
    assign active_input_upper = flg.act_hi;
    assign active_input_lower = flg.act_lo;
    assign tripped_input_upper_flag = flg.trp_hi;
    assign tripped_input_lower_flag = flg.trp_lo;

    // checks
    AST_HYST_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_go && sel_upper && pstrb[3] |=> lim.hyst == $past(pwdata[31:30]))
        else $error("hysteresis not taken from bits 31:30");

    AST_UPPER_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flg.act_hi) |-> $past(result_valid) && ($past(result) > $past(upper_ff[15:4])))
        else $error("upper alarm rose without result above limit");

    AST_LOWER_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flg.act_lo) |-> $past(result_valid) && ($past(result) < $past(lower_ff[15:4])))
        else $error("lower alarm rose without result below limit");

    AST_UPPER_BYTE2: assert property (@(posedge pclk) disable iff (!presetn)
        rd_go && sel_upper |=> pready && prdata[23:16] == 8'h00)
        else $error("upper word byte 2 not zero");

    AST_LOWER_TOP: assert property (@(posedge pclk) disable iff (!presetn)
        rd_go && sel_lower |=> pready && prdata[31:16] == 16'h0000)
        else $error("lower word top half not zero");

    AST_UPPER_LANE1: assert property (@(posedge pclk) disable iff (!presetn)
        wr_go && sel_upper && pstrb[1] && !pstrb[0]
        |=> upper_ff[15:8] == $past(pwdata[15:8]) && $stable(upper_ff[7:0]))
        else $error("upper word byte lanes misplaced");

    AST_LOWER_LANE0: assert property (@(posedge pclk) disable iff (!presetn)
        wr_go && sel_lower && pstrb[0] && !pstrb[1]
        |=> lower_ff[7:0] == $past(pwdata[7:0]) && $stable(lower_ff[15:8]))
        else $error("lower word byte lanes misplaced");

    AST_OVERALL: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 any_tripped_alarm == $past(flg.trp_lo || flg.trp_hi))
        else $error("overall alarm not or of tripped flags");

    // a fresh result beyond a limit must raise the active level on the next edge
    AST_UPPER_SET: assert property (@(posedge pclk) disable iff (!presetn)
        result_valid && !flg.act_hi && (result > lim.upper) |=> flg.act_hi)
        else $error("upper alarm not raised by result above limit");

    AST_LOWER_SET: assert property (@(posedge pclk) disable iff (!presetn)
        result_valid && !flg.act_lo && (result < lim.lower) |=> flg.act_lo)
        else $error("lower alarm not raised by result below limit");

    AST_LOWER_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(flg.act_lo) |-> $past(result_valid)
            && ({1'b0, $past(result)} > {1'b0, $past(lim.lower)} + {11'h000, $past(lim.hyst)}))
        else $error("lower alarm released inside hysteresis band");

    AST_UPPER_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(flg.act_hi) |-> $past(result_valid)
            && ({1'b0, $past(result)} + {11'h000, $past(lim.hyst)} < {1'b0, $past(lim.upper)}))
        else $error("upper alarm released inside hysteresis band");

    AST_TRIP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        flg.trp_hi && !(rd_go && sel_status) |=> flg.trp_hi)
        else $error("tripped flag lost without status read");

    AST_LOWER_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        flg.trp_lo && !(rd_go && sel_status) |=> flg.trp_lo)
        else $error("tripped lower flag lost without status read");

    // a new event in the clearing cycle is allowed to survive, so it is left out here
    AST_STATUS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        rd_go && sel_status && !rise_hi && !rise_lo |=> !flg.trp_hi && !flg.trp_lo)
        else $error("tripped flags not cleared by status read");

    AST_TRIP_SET: assert property (@(posedge pclk) disable iff (!presetn)
        rise_hi |=> flg.trp_hi [*2] or (flg.trp_hi ##1 $past(rd_go && sel_status)))
        else $error("tripped flag not set by alarm event");

endmodule : iat_input_alarm_regs

//--- design/iat_pkg.sv
// package: register map, field layout, reset values and carrier types of the input alarm block
package iat_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_STATUS = 8'h20; // alarm flags, tripped bits clear on read
    localparam logic [7:0] OFS_UPPER = 8'h24; // hysteresis byte and upper limit
    localparam logic [7:0] OFS_LOWER = 8'h28; // lower limit
    localparam logic [7:0] OFS_MASK = 8'h30; // interrupt enables, same layout as status

    // values after reset
    localparam logic [15:0] UPPER_RST = 16'hFFFF; // upper limit at full scale
    localparam logic [15:0] LOWER_RST = 16'h0000; // lower limit at zero
    localparam logic [7:0] HYST_RST = 8'h00; // no hysteresis
    localparam logic [31:0] MASK_RST = 32'h0000_0000; // all interrupts disabled

    // field positions
    localparam int HYST_LSB = 6; // hysteresis code sits in the top two bits of its byte
    localparam int LIMIT_LSB = 4; // limits compare on bits 15:4
    localparam int STS_OVW_BIT = 0; // or of all tripped flags
    localparam int STS_TRP_HI_BIT = 4; // tripped upper
    localparam int STS_TRP_LO_BIT = 5; // tripped lower
    localparam int STS_ACT_HI_BIT = 10; // active upper
    localparam int STS_ACT_LO_BIT = 11; // active lower

    // comparison view of the limit registers
    typedef struct packed {
        logic [1:0] hyst; // hysteresis in result lsbs
        logic [11:0] upper; // upper limit, 12 bits
        logic [11:0] lower; // lower limit, 12 bits
    } iat_limits_t;

    // alarm flags as seen by software and pins
    typedef struct packed {
        logic act_lo; // lower comparison active now
        logic act_hi; // upper comparison active now
        logic trp_lo; // lower alarm seen since last status read
        logic trp_hi; // upper alarm seen since last status read
    } iat_flags_t;

    // merge write data into a stored word under the byte strobes, lane 0 = bits 7:0
    function automatic logic [31:0] iat_byte_merge(input logic [31:0] old_word,
                                                   input logic [31:0] new_word,
                                                   input logic [3:0] strb);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction : iat_byte_merge

endpackage : iat_pkg

//--- design/iat_sticky_flags.sv
// module: sticky event flags, cleared together by a pulse, a set wins over the clear
module iat_sticky_flags #(
    parameter int W = 2 // number of flags
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // events and clear
    input wire logic [W-1:0] set,
    input wire logic clr,
    // flags
    output logic [W-1:0] flags_ff
);
    // an event in the clearing cycle survives, so a read never swallows it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= set | (flags_ff & ~{W{clr}});
        end
    end

endmodule : iat_sticky_flags

//--- verif/iat_input_alarm_regs_tb_top.sv
// testbench: register access, limit comparison, hysteresis, sticky flags and interrupt
module iat_input_alarm_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // clock, reset and apb request
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    // conversion results
    logic result_valid = 1'b0;
    logic [11:0] result = 12'h000;
    // design outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic active_input_upper;
    logic active_input_lower;
    logic tripped_input_upper_flag;
    logic tripped_input_lower_flag;
    logic any_tripped_alarm;
    logic irq;
    // bookkeeping
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rdata;
    logic rerr;

    // 100 ns period
    always #50 pclk = ~pclk;

    iat_input_alarm_regs iat_input_alarm_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .result_valid(result_valid), .result(result),
        .active_input_upper(active_input_upper), .active_input_lower(active_input_lower),
        .tripped_input_upper_flag(tripped_input_upper_flag),
        .tripped_input_lower_flag(tripped_input_lower_flag),
        .any_tripped_alarm(any_tripped_alarm), .irq(irq)
    );

    // single comparison point, four-state exact
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // hang guard: whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       input logic [3:0] strb);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        pstrb <= wr ? strb : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
    endtask : apb

    // read a word and compare it
    task automatic rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000, 4'h0);
        check(name, rdata, exp);
    endtask : rd

    // one result pulse, then let active, tripped and irq settle
    task automatic send(input logic [11:0] v);
        @(posedge pclk);
        result_valid <= 1'b1;
        result <= v;
        @(posedge pclk);
        result_valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : send

    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and read-only bytes
        rd("upper reset", iat_pkg::OFS_UPPER, 32'h0000_FFFF);
        rd("lower reset", iat_pkg::OFS_LOWER, 32'h0000_0000);
        rd("status reset", iat_pkg::OFS_STATUS, 32'h0000_0000);
        rd("mask reset", iat_pkg::OFS_MASK, 32'h0000_0000);
        apb(1'b1, iat_pkg::OFS_UPPER, 32'hFFFF_FFFF, 4'hF);
        rd("upper byte2 zero", iat_pkg::OFS_UPPER, 32'hFF00_FFFF);
        apb(1'b1, iat_pkg::OFS_LOWER, 32'hFFFF_FFFF, 4'hF);
        rd("lower top zero", iat_pkg::OFS_LOWER, 32'h0000_FFFF);
        // single byte lanes land in their own bytes only
        apb(1'b1, iat_pkg::OFS_UPPER, 32'hA5A5_A5A5, 4'h2);
        rd("upper lane1", iat_pkg::OFS_UPPER, 32'hFF00_A5FF);
        apb(1'b1, iat_pkg::OFS_UPPER, 32'h1234_5678, 4'h8);
        rd("upper lane3", iat_pkg::OFS_UPPER, 32'h1200_A5FF);
        apb(1'b1, iat_pkg::OFS_LOWER, 32'h5A5A_5A50, 4'h1);
        rd("lower lane0", iat_pkg::OFS_LOWER, 32'h0000_FF50);
        apb(1'b1, iat_pkg::OFS_LOWER, 32'h5A5A_5A50, 4'h4);
        rd("lower lane2", iat_pkg::OFS_LOWER, 32'h0000_FF50);
        // unmapped place refused, status not writable
        rd("unmapped data", 8'h3C, 32'h0000_0000);
        check("unmapped err", {31'h0, rerr}, 32'h0000_0001);
        apb(1'b1, iat_pkg::OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
        rd("status unwritten", iat_pkg::OFS_STATUS, 32'h0000_0000);
        apb(1'b1, iat_pkg::OFS_MASK, 32'h0000_0010, 4'hF);
        rd("mask readback", iat_pkg::OFS_MASK, 32'h0000_0010);
        // hysteresis code 2, upper limit 800h, lower limit 100h, zero low nibbles
        apb(1'b1, iat_pkg::OFS_UPPER, 32'h8000_8000, 4'hF);
        apb(1'b1, iat_pkg::OFS_LOWER, 32'h0000_1000, 4'hF);
        send(12'h800);
        check("upper at limit", {31'h0, active_input_upper}, 32'h0);
        send(12'h801);
        check("upper above", {31'h0, active_input_upper}, 32'h1);
        check("upper tripped", {31'h0, tripped_input_upper_flag}, 32'h1);
        check("overall set", {31'h0, any_tripped_alarm}, 32'h1);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        send(12'h7FF);
        check("upper in band", {31'h0, active_input_upper}, 32'h1);
        send(12'h7FD);
        check("upper released", {31'h0, active_input_upper}, 32'h0);
        check("upper still tripped", {31'h0, tripped_input_upper_flag}, 32'h1);
        rd("status upper", iat_pkg::OFS_STATUS, 32'h0000_0011);
        repeat (3) @(posedge pclk);
        check("upper cleared", {31'h0, tripped_input_upper_flag}, 32'h0);
        check("overall clear", {31'h0, any_tripped_alarm}, 32'h0);
        check("irq clear", {31'h0, irq}, 32'h0);
        // lower side, masked out of the interrupt
        send(12'h100);
        check("lower at limit", {31'h0, active_input_lower}, 32'h0);
        send(12'h0FF);
        check("lower below", {31'h0, active_input_lower}, 32'h1);
        check("lower tripped", {31'h0, tripped_input_lower_flag}, 32'h1);
        check("overall lower", {31'h0, any_tripped_alarm}, 32'h1);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd("status lower", iat_pkg::OFS_STATUS, 32'h0000_0821);
        send(12'h102);
        check("lower in band", {31'h0, active_input_lower}, 32'h1);
        send(12'h103);
        check("lower released", {31'h0, active_input_lower}, 32'h0);
        // only the top two bits of the hysteresis byte count: code 0 here
        apb(1'b1, iat_pkg::OFS_UPPER, 32'h3F00_8000, 4'hF);
        send(12'h801);
        check("upper again", {31'h0, active_input_upper}, 32'h1);
        send(12'h7FF);
        check("no band", {31'h0, active_input_upper}, 32'h0);
        check("upper tripped again", {31'h0, tripped_input_upper_flag}, 32'h1);
        // reset in mid-run: flags drop at once, registers return to their reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check("trip in reset", {31'h0, tripped_input_upper_flag}, 32'h0);
        check("overall in reset", {31'h0, any_tripped_alarm}, 32'h0);
        check("irq in reset", {31'h0, irq}, 32'h0);
        presetn <= 1'b1;
        rd("upper after reset", iat_pkg::OFS_UPPER, 32'h0000_FFFF);
        rd("status after reset", iat_pkg::OFS_STATUS, 32'h0000_0000);
        wrap_up();
    end

endmodule : iat_input_alarm_regs_tb_top
